//--- src/dbd_cfg.svh
`ifndef DBD_CFG_SVH
`define DBD_CFG_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define DBD_OFS_FLAGS 8'h04
`define DBD_OFS_UNMASK 8'h00
`define DBD_RST_FLAGS 32'h00000000
`define DBD_RST_UNMASK 32'h00000000
`define DBD_UNMAPPED_RDATA 32'h00000000
`endif

//--- src/dbd_pkg.sv
package dbd_pkg;
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } dbd_req_s;
  typedef enum logic [0:0] {
    DBD_IDLE,
    DBD_DONE
  } dbd_bus_e;
endpackage : dbd_pkg

//--- src/dbd_block_done.sv
`timescale 1ns/1ps
`include "dbd_cfg.svh"
module dbd_block_done
  import dbd_pkg::*;
#(
  parameter int NUM_CHAN = 32
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [NUM_CHAN-1:0] chan_block_done_evt,
  input wire dbd_req_s avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic block_irq,
  output logic [NUM_CHAN-1:0] chan_block_irq
);

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  // the flags share one bus word, so more than 32 channels cannot be served
  if (NUM_CHAN < 1 || NUM_CHAN > 32) begin : g_bad_chan
    $error("NUM_CHAN must be 1..32");
  end

  // both registers must decode apart, or one write would land in both
  if (`DBD_OFS_FLAGS == `DBD_OFS_UNMASK) begin : g_bad_map
    $error("flag and unmask offsets collide");
  end

  // byte addresses off a word boundary would split a register across two words
  if ((`DBD_OFS_FLAGS % 4) != 0 || (`DBD_OFS_UNMASK % 4) != 0) begin : g_bad_align
    $error("register offsets must be word aligned");
  end

  // ----------------------------------------
  // constants
  // ----------------------------------------
  localparam int LANES = 4;
  localparam int LANE_W = 8;

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  // every output is one of these, so nothing combinational reaches a pin
  dbd_bus_e bus_q;
  dbd_bus_e bus_d;
  logic wait_q;
  logic wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [NUM_CHAN-1:0] flags_q;
  logic [NUM_CHAN-1:0] flags_d;
  logic [NUM_CHAN-1:0] unmask_q;
  logic [NUM_CHAN-1:0] unmask_d;
  logic [NUM_CHAN-1:0] irq_vec_q;
  logic [NUM_CHAN-1:0] irq_vec_d;
  logic irq_q;
  logic irq_d;

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  logic rd_req;
  logic wr_req;
  logic req;
  logic idle;
  logic hit_flags;
  logic hit_unmask;
  logic rd_take;
  logic wr_take;
  logic wr_flags;
  logic wr_unmask;

  assign rd_req = avs_req.read;
  assign wr_req = avs_req.write;
  assign req = rd_req | wr_req;
  assign idle = (bus_q == DBD_IDLE);
  assign hit_flags = (avs_req.address == `DBD_OFS_FLAGS);
  assign hit_unmask = (avs_req.address == `DBD_OFS_UNMASK);

  // a request counts once, at the edge that finds the block idle;
  // the master still holds it through the answer cycle, which must not apply it again
  assign rd_take = rd_req & idle;
  assign wr_take = wr_req & idle;
  assign wr_flags = wr_take & hit_flags;
  assign wr_unmask = wr_take & hit_unmask;

  // ----------------------------------------
  // byte lanes
  // ----------------------------------------
  logic [31:0] wmask;
  logic [31:0] wbits;

  // a lane left out of byteenable neither clears flags nor changes unmask bits
  for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
    assign wmask[LANE_W*lane +: LANE_W] = {LANE_W{avs_req.byteenable[lane]}};
  end

  assign wbits = avs_req.writedata & wmask;

  // ----------------------------------------
  // flag next value
  // ----------------------------------------
  logic [NUM_CHAN-1:0] clr;
  logic [NUM_CHAN-1:0] set;

  always_comb begin
    flags_d = flags_q;
    clr = '0;
    set = chan_block_done_evt;
    if (wr_flags) begin
      // zeros in the written word leave their flags alone
      clr = wbits[NUM_CHAN-1:0];
    end
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (clr[c]) begin
        flags_d[c] = 1'b0;
      end
      // set is applied last so a completion in the clearing cycle is never lost
      if (set[c]) begin
        flags_d[c] = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // flag register
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags_q <= NUM_CHAN'(`DBD_RST_FLAGS);
    end else begin
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------
  // unmask register
  // ----------------------------------------
  // only the lanes named by byteenable change; the others keep their bits
  always_comb begin
    unmask_d = unmask_q;
    if (wr_unmask) begin
      unmask_d = (unmask_q & ~wmask[NUM_CHAN-1:0]) | wbits[NUM_CHAN-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      unmask_q <= NUM_CHAN'(`DBD_RST_UNMASK);
    end else begin
      unmask_q <= unmask_d;
    end
  end

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  // built from next values so the lines move on the same edge as flag and unmask;
  // the cost is a longer path from the bus and the event inputs to these flops
  always_comb begin
    irq_vec_d = '0;
    for (int c = 0; c < NUM_CHAN; c++) begin
      // a masked channel keeps its flag but stays silent
      irq_vec_d[c] = flags_d[c] & unmask_d[c];
    end
    irq_d = |irq_vec_d;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_vec_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_vec_q <= irq_vec_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------
  // readback words
  // ----------------------------------------
  logic [31:0] flags_word;
  logic [31:0] unmask_word;

  // with fewer channels the unused upper bits read as zero
  always_comb begin
    flags_word = '0;
    unmask_word = '0;
    flags_word[NUM_CHAN-1:0] = flags_q;
    unmask_word[NUM_CHAN-1:0] = unmask_q;
  end

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  // one wait state per access: the answer is registered, so readdata stands
  // at the edge that sees waitrequest low; a read returns the state before
  // the edge that takes it, and readdata holds until the next read
  // limitation: at most one access every two cycles
  always_comb begin
    bus_d = bus_q;
    rdata_d = rdata_q;
    wait_d = 1'b1;
    unique case (bus_q)
      DBD_IDLE: begin
        if (req) begin
          bus_d = DBD_DONE;
          wait_d = 1'b0;
          if (rd_take) begin
            // unmapped reads are still answered, with a fixed word
            rdata_d = `DBD_UNMAPPED_RDATA;
            if (hit_flags) begin
              rdata_d = flags_word;
            end else if (hit_unmask) begin
              rdata_d = unmask_word;
            end
          end
        end
      end
      DBD_DONE: begin
        bus_d = DBD_IDLE;
      end
    endcase
  end

  // waitrequest is high in reset and idle, low only in the answer cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bus_q <= DBD_IDLE;
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      bus_q <= bus_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign chan_block_irq = irq_vec_q;
  assign block_irq = irq_q;

endmodule : dbd_block_done

//--- bench/dbd_block_done_props.sv
`timescale 1ns/1ps
module dbd_block_done_props
  import dbd_pkg::*;
#(parameter int NUM_CHAN = 32) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [NUM_CHAN-1:0] chan_block_done_evt,
  input wire dbd_req_s avs_req,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic block_irq,
  input wire logic [NUM_CHAN-1:0] chan_block_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_sum; block_irq == |chan_block_irq; endproperty
  a_sum: assert property (p_sum) else $error("irq summary wrong");
  property p_ans; (avs_req.read || avs_req.write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("request not answered");
  // a write is held through its answer cycle, so one past cycle covers both irq timings
  property p_hold; |($past(chan_block_irq) & ~chan_block_irq) |-> $past(avs_req.write); endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without write");
  property p_rise; |(chan_block_irq & ~$past(chan_block_irq)) |-> $past(|chan_block_done_evt || avs_req.write); endproperty
  a_rise: assert property (p_rise) else $error("irq rose without cause");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("answer held too long");
  property p_quiet; !(avs_req.read || avs_req.write) && avs_waitrequest |=> avs_waitrequest; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
endmodule : dbd_block_done_props
bind dbd_block_done dbd_block_done_props #(.NUM_CHAN(NUM_CHAN)) props_i (.*);

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dbd_pkg::*;
  logic core_clk = 0;
  logic reset = 1;
  logic [31:0] evt = '0;
  logic [31:0] rdata, chirq;
  logic waitreq, irq;
  dbd_req_s req = '0;
  logic [3:0] be = 4'hF;
  int error_cnt = 0;
  int compares = 0;
  dbd_block_done dbd_block_done_i (.core_clk(core_clk), .reset(reset), .chan_block_done_evt(evt),
    .avs_req(req), .avs_readdata(rdata), .avs_waitrequest(waitreq), .block_irq(irq), .chan_block_irq(chirq));
  initial forever #12.5 core_clk = ~core_clk;
  task chk(string n, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // idle cycle after release keeps two requests from landing in one time step
  task bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
    req <= '{a, !w, w, d, be};
    do @(posedge core_clk); while (waitreq !== 1'b0);
    q = rdata;
    req <= '0;
    @(posedge core_clk);
  endtask : bus
  task rdc(string n, logic [7:0] a, logic [31:0] e);
    logic [31:0] q;
    bus(0, a, 32'h0, q);
    chk(n, e, q);
  endtask : rdc
  task s_set;
    logic [31:0] q;
    rdc("flags", 8'h04, 32'h0);
    bus(1, 8'h00, 32'h80000001, q);
    evt <= 32'h80002001;
    @(posedge core_clk);
    evt <= '0;
    rdc("flags", 8'h04, 32'h80002001);
    chk("chan irq", 32'h80000001, chirq);
    chk("irq", 32'h1, {31'h0, irq});
  endtask : s_set
  task s_clear;
    logic [31:0] q;
    bus(1, 8'h04, 32'h00002000, q);
    rdc("flags", 8'h04, 32'h80000001);
    be = 4'h1;
    bus(1, 8'h04, 32'hFFFFFFFF, q);
    be = 4'hF;
    rdc("flags", 8'h04, 32'h80000000);
  endtask : s_clear
  task s_race;
    logic [31:0] q;
    fork
      bus(1, 8'h04, 32'h80000001, q);
      begin
        evt <= 32'h1;
        @(posedge core_clk);
        evt <= '0;
      end
    join
    rdc("flags", 8'h04, 32'h1);
    bus(1, 8'h00, 32'h0, q);
    chk("irq", 32'h0, {31'h0, irq});
    rdc("unmapped", 8'h08, 32'h0);
  endtask : s_race
  task s_reset;
    logic [31:0] q;
    bus(1, 8'h00, 32'h00000001, q);
    chk("chan irq", 32'h1, chirq);
    reset <= 1;
    repeat (2) @(posedge core_clk);
    chk("waitreq", 32'h1, {31'h0, waitreq});
    reset <= 0;
    rdc("flags", 8'h04, 32'h0);
    rdc("unmask", 8'h00, 32'h0);
    chk("chan irq", 32'h0, chirq);
  endtask : s_reset
  task finish_test;
    if (error_cnt == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (500) @(posedge core_clk);
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 0;
    s_set();
    s_clear();
    s_race();
    s_reset();
    finish_test();
  end
endmodule : testbench
